// >>> dv/encoder_freeze_marker_capture_props.sv
module capture_port_props (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [7:0] first_freeze_unit_src,
  input wire logic [7:0] second_freeze_unit_src,
  input wire logic ref_unit_sel,
  input wire logic fb_unit_sel,
  input wire logic irq
);
  logic tk;
  logic rd_r;
  logic ctl_r;
  logic unm_r;
  // *****************
  // bus phase tracking
  // *****************
  assign tk = hsel && hready && htrans[1];
  // remember what the address phase asked for
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_r <= 1'b0;
      ctl_r <= 1'b0;
      unm_r <= 1'b0;
    end else begin
      rd_r <= tk && !hwrite;
      ctl_r <= tk && hwrite && haddr == 8'h00;
      unm_r <= tk && !hwrite && (haddr > 8'h30 || haddr[1:0] != 2'h0);
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  ready_okay_a: assert property (hreadyout && !hresp)
    else $error("bus stalled or error");
  src_four_a: assert property ($changed(first_freeze_unit_src) |->
    first_freeze_unit_src == 8'h04) else $error("trigger source not four");
  src_pair_a: assert property (
    first_freeze_unit_src == second_freeze_unit_src)
    else $error("trigger sources differ");
  ref_sel_a: assert property ($past(ctl_r) |->
    ref_unit_sel == $past(hwdata[3])) else $error("ref unit wrong");
  fb_sel_a: assert property ($past(ctl_r) |->
    fb_unit_sel == $past(hwdata[4])) else $error("fb unit wrong");
  sel_hold_a: assert property ($changed({ref_unit_sel, fb_unit_sel})
    |-> $past(ctl_r)) else $error("unit select moved alone");
  unmapped_zero_a: assert property (unm_r |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property ($changed(hrdata) |-> rd_r)
    else $error("read data moved without read");
  irq_reset_a: assert property ($fell(rst) |-> !irq)
    else $error("irq high after reset");
  cover property (rd_r);
  cover property ($rose(irq));
  cover property ($changed(first_freeze_unit_src));
endmodule : capture_port_props

bind encoder_freeze_marker_capture capture_port_props capture_port_props_i (
  .ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hrdata, .hreadyout, .hresp, .first_freeze_unit_src,
  .second_freeze_unit_src, .ref_unit_sel, .fb_unit_sel, .irq);

// >>> dv/encoder_freeze_marker_capture_tb.sv
module encoder_freeze_marker_capture_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic e; logic rs; logic fs; logic [31:0] b;} row_t;
  row_t rows [4] = '{'{1'b0, 1'b0, 1'b0, 32'h1000},
    '{1'b1, 1'b1, 1'b1, 32'h2000}, '{1'b0, 1'b1, 1'b0, 32'h3000},
    '{1'b1, 1'b0, 1'b1, 32'h4000}};
  logic ref_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, base = 32'h0, q, b, hrdata;
  logic frz = 1'b0, rmk = 1'b0, fmk = 1'b0;
  logic hreadyout, hresp, rsel, fsel, irq;
  logic [7:0] src1, src2;
  logic [31:0] p [8];
  int miscompares = 0, total_checks = 0, cyc = 0;
  // ****************
  // clock, parts
  // ****************
  always #2.5 ref_clk = ~ref_clk;
  encoder_source_model encoder_source_model_i (.base(base), .pos(p));
  encoder_freeze_marker_capture encoder_freeze_marker_capture_i (
    .ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .digital_in({7'h5A, frz}), .ref_primary_position_source(p[0]),
    .ref_secondary_position_source(p[1]), .ref_primary_rev(p[2]),
    .ref_secondary_rev(p[3]), .fb_primary_position_source(p[4]),
    .fb_secondary_position_source(p[5]), .fb_primary_rev(p[6]),
    .fb_secondary_rev(p[7]), .ref_marker(rmk), .fb_marker(fmk),
    .first_freeze_unit_src(src1), .second_freeze_unit_src(src2),
    .ref_unit_sel(rsel), .fb_unit_sel(fsel), .irq);
  // hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      miscompares++;
      final_report();
    end
  end
  // ****************
  // tasks
  // ****************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  // one single word transfer, read data left in q
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    check(q, e);
  endtask : rd
  task automatic tog(input logic v);
    @(posedge ref_clk);
    frz <= v;
    repeat (3) @(posedge ref_clk);
  endtask : tog
  task automatic mk(input logic r, input logic f);
    @(posedge ref_clk);
    rmk <= r;
    fmk <= f;
    @(posedge ref_clk);
    rmk <= 1'b0;
    fmk <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask : mk
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  // ****************
  // sequence
  // ****************
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 14; i++) rd(8'(4 * i), 32'h0);
    check(32'(src1), 32'h0);
    $display("test reset done");
    foreach (rows[i]) begin
      b = rows[i].b;
      tog(!rows[i].e);
      bus(8'h00, 1'b1, {27'h0, rows[i].fs, rows[i].rs, 1'b0, rows[i].e, 1'b1});
      bus(8'h0C, 1'b1, 32'hF);
      // wrong edge first: it must not capture the decoy value
      base <= 32'h9999;
      tog(rows[i].e);
      base <= b;
      tog(!rows[i].e);
      base <= 32'h9999;
      tog(rows[i].e);
      tog(!rows[i].e);
      rd(8'h0C, 32'h3);
      rd(8'h10, rows[i].rs ? ~b : b);
      rd(8'h14, b + (rows[i].rs ? 32'h2 : 32'h1));
      rd(8'h18, b + (rows[i].fs ? 32'h4 : 32'h3));
      rd(8'h1C, b + (rows[i].fs ? 32'h6 : 32'h5));
      check(32'(rsel), 32'(rows[i].rs));
      check(32'(fsel), 32'(rows[i].fs));
      $display("test row %0d done", i);
    end
    bus(8'h00, 1'b1, 32'h0);
    bus(8'h0C, 1'b1, 32'hF);
    tog(1'b1);
    rd(8'h0C, 32'h0);
    rd(8'h10, 32'h4000);
    bus(8'h00, 1'b1, 32'h1);
    bus(8'h00, 1'b1, 32'h5);
    rd(8'h30, 32'h0404);
    $display("test enable done");
    bus(8'h04, 1'b1, 32'hF);
    base <= 32'hA000;
    mk(1'b1, 1'b1);
    base <= 32'hB000;
    mk(1'b1, 1'b0);
    rd(8'h20, 32'hB000);
    rd(8'h24, 32'hB001);
    rd(8'h28, 32'hA003);
    rd(8'h2C, 32'hA005);
    rd(8'h0C, 32'hC);
    bus(8'h08, 1'b1, 32'h4);
    #1;
    check(32'(irq), 32'h1);
    bus(8'h04, 1'b1, 32'h4);
    #1;
    check(32'(irq), 32'h0);
    rd(8'h04, 32'h8);
    bus(8'h0C, 1'b1, 32'hF);
    rd(8'h0C, 32'h0);
    $display("test markers done");
    // reset in mid-run with flags, status and sources all set
    mk(1'b1, 1'b1);
    check(32'(irq), 32'h1);
    rst <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    check(32'(irq), 32'h0);
    rd(8'h0C, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h30, 32'h0);
    rd(8'h00, 32'h0);
    $display("test mid reset done");
    final_report();
  end
endmodule : encoder_freeze_marker_capture_tb

// >>> dv/encoder_source_model.sv
module encoder_source_model (
  input wire logic [31:0] base,
  output logic [31:0] pos [8]
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************
  // encoder values
  // ****************
  // distinct values per source so a wrong pick shows
  always_comb begin
    pos[0] = base;
    pos[1] = ~base;
    for (int i = 2; i < 8; i++) begin
      pos[i] = base + 32'(i - 1);
    end
  end
endmodule : encoder_source_model

// >>> rtl/encoder_freeze_marker_capture.sv
`include "freeze_capture_params.svh"

module encoder_freeze_marker_capture
  import freeze_capture_pkg::*;
#(
  parameter int POS_W = 32,
  parameter int REV_W = 32,
  parameter int DIN_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // encoder sources
  input wire logic [DIN_W-1:0] digital_in,
  input wire logic [POS_W-1:0] ref_primary_position_source,
  input wire logic [POS_W-1:0] ref_secondary_position_source,
  input wire logic [REV_W-1:0] ref_primary_rev,
  input wire logic [REV_W-1:0] ref_secondary_rev,
  input wire logic [POS_W-1:0] fb_primary_position_source,
  input wire logic [POS_W-1:0] fb_secondary_position_source,
  input wire logic [REV_W-1:0] fb_primary_rev,
  input wire logic [REV_W-1:0] fb_secondary_rev,
  input wire logic ref_marker,
  input wire logic fb_marker,
  // freeze unit configuration toward the drive, and the interrupt
  output logic [7:0] first_freeze_unit_src,
  output logic [7:0] second_freeze_unit_src,
  output logic ref_unit_sel,
  output logic fb_unit_sel,
  output logic irq
);

  // ****************************************
  // bus slave
  // ****************************************
  logic ctrl_en_r;
  logic ctrl_edge_r;
  logic ref_sel_r;
  logic fb_sel_r;
  logic [`NUM_EVENTS-1:0] stat_r;
  logic [`NUM_EVENTS-1:0] mask_r;
  logic [`NUM_EVENTS-1:0] flag_r;
  logic [`NUM_EVENTS-1:0] flag_clr;
  logic [`NUM_EVENTS-1:0] stat_clr;
  logic [`NUM_EVENTS-1:0] ev;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic wr_stb;
  logic reinitialise_command_stb;
  logic init_done_r;
  logic [POS_W-1:0] ref_frz_pos_r, fb_frz_pos_r;
  logic [REV_W-1:0] ref_frz_rev_r, fb_frz_rev_r;
  logic [POS_W-1:0] ref_mrk_pos_r, fb_mrk_pos_r;
  logic [REV_W-1:0] ref_mrk_rev_r, fb_mrk_rev_r;

  // capture write address phase
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else if (hready) begin
      wr_pend_r <= hsel & htrans[1] & hwrite;
      wr_addr_r <= haddr;
    end
  end

  // zero wait state, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wr_stb = wr_pend_r;
  assign reinitialise_command_stb = wr_stb && (wr_addr_r == `OFS_CTRL) &&
    hwdata[`CTRL_REINITIALISE_COMMAND_BIT];

  // control register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_en_r <= 1'b0;
      ctrl_edge_r <= 1'b0;
      ref_sel_r <= 1'b0;
      fb_sel_r <= 1'b0;
    end else if (wr_stb && wr_addr_r == `OFS_CTRL) begin
      ctrl_en_r <= hwdata[`CTRL_EN_BIT];
      ctrl_edge_r <= hwdata[`CTRL_EDGE_BIT];
      ref_sel_r <= hwdata[`CTRL_REF_SEL_BIT];
      fb_sel_r <= hwdata[`CTRL_FB_SEL_BIT];
    end
  end

  // mask register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mask_r <= '0;
    end else if (wr_stb && wr_addr_r == `OFS_MASK) begin
      mask_r <= hwdata[`NUM_EVENTS-1:0];
    end
  end

  // write-one-to-clear strobes
  assign stat_clr = (wr_stb && wr_addr_r == `OFS_STAT) ?
    hwdata[`NUM_EVENTS-1:0] : '0;
  assign flag_clr = (wr_stb && wr_addr_r == `OFS_FLAGS) ?
    hwdata[`NUM_EVENTS-1:0] : '0;

  // read data registered from the address phase, driven in the data phase
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      unique case (haddr)
        `OFS_CTRL: hrdata <= 32'({fb_sel_r, ref_sel_r, 1'b0,
                                  ctrl_edge_r, ctrl_en_r});
        `OFS_STAT: hrdata <= 32'(stat_r);
        `OFS_MASK: hrdata <= 32'(mask_r);
        `OFS_FLAGS: hrdata <= 32'(flag_r);
        `OFS_REF_FRZ_POS: hrdata <= 32'(ref_frz_pos_r);
        `OFS_REF_FRZ_REV: hrdata <= 32'(ref_frz_rev_r);
        `OFS_FB_FRZ_POS: hrdata <= 32'(fb_frz_pos_r);
        `OFS_FB_FRZ_REV: hrdata <= 32'(fb_frz_rev_r);
        `OFS_REF_MRK_POS: hrdata <= 32'(ref_mrk_pos_r);
        `OFS_REF_MRK_REV: hrdata <= 32'(ref_mrk_rev_r);
        `OFS_FB_MRK_POS: hrdata <= 32'(fb_mrk_pos_r);
        `OFS_FB_MRK_REV: hrdata <= 32'(fb_mrk_rev_r);
        `OFS_TRIG_SRC: hrdata <= {16'h0000, second_freeze_unit_src,
                                  first_freeze_unit_src};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // freeze unit configuration
  // ****************************************
  // only a reinitialise command with enable already set loads trigger sources; the power-up pass sees enable zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      init_done_r <= 1'b0;
      first_freeze_unit_src <= `TRIG_RESET_VAL;
      second_freeze_unit_src <= `TRIG_RESET_VAL;
    end else begin
      init_done_r <= 1'b1;
      if ((!init_done_r || reinitialise_command_stb) && ctrl_en_r) begin
        first_freeze_unit_src <= `TRIG_COMMON_LINE;
        second_freeze_unit_src <= `TRIG_COMMON_LINE;
      end
    end
  end

  // unit follows encoder source selection
  assign ref_unit_sel = ref_sel_r;
  assign fb_unit_sel = fb_sel_r;

  // ****************************************
  // freeze edge detection
  // ****************************************
  logic frz_in_r;
  logic frz_edge;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      frz_in_r <= 1'b0;
    end else begin
      frz_in_r <= digital_in[`FREEZE_IN_BIT];
    end
  end

  // rising when select is zero, falling when one
  assign frz_edge = ctrl_edge_r ?
    (frz_in_r & ~digital_in[`FREEZE_IN_BIT]) :
    (~frz_in_r & digital_in[`FREEZE_IN_BIT]);

  // ****************************************
  // source selection
  // ****************************************
  logic [POS_W-1:0] ref_pos, fb_pos;
  logic [REV_W-1:0] ref_rev, fb_rev;
  assign ref_pos = (ref_sel_r == UNIT_SECOND) ?
    ref_secondary_position_source : ref_primary_position_source;
  assign ref_rev = (ref_sel_r == UNIT_SECOND) ?
    ref_secondary_rev : ref_primary_rev;
  assign fb_pos = (fb_sel_r == UNIT_SECOND) ?
    fb_secondary_position_source : fb_primary_position_source;
  assign fb_rev = (fb_sel_r == UNIT_SECOND) ?
    fb_secondary_rev : fb_primary_rev;

  // ****************************************
  // events
  // ****************************************
  logic ref_frz_take, fb_frz_take;
  // freeze captured only when enabled and flag clear
  assign ref_frz_take = frz_edge & ctrl_en_r & ~flag_r[`FLAG_REF_FRZ];
  assign fb_frz_take = frz_edge & ctrl_en_r & ~flag_r[`FLAG_FB_FRZ];
  assign ev[`FLAG_REF_FRZ] = ref_frz_take;
  assign ev[`FLAG_FB_FRZ] = fb_frz_take;
  assign ev[`FLAG_REF_MRK] = ref_marker;
  assign ev[`FLAG_FB_MRK] = fb_marker;

  // freeze result registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ref_frz_pos_r <= '0;
      ref_frz_rev_r <= '0;
    end else if (ref_frz_take) begin
      ref_frz_pos_r <= ref_pos;
      ref_frz_rev_r <= ref_rev;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fb_frz_pos_r <= '0;
      fb_frz_rev_r <= '0;
    end else if (fb_frz_take) begin
      fb_frz_pos_r <= fb_pos;
      fb_frz_rev_r <= fb_rev;
    end
  end

  // marker results, overwritten on every marker
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ref_mrk_pos_r <= '0;
      ref_mrk_rev_r <= '0;
    end else if (ref_marker) begin
      ref_mrk_pos_r <= ref_pos;
      ref_mrk_rev_r <= ref_rev;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fb_mrk_pos_r <= '0;
      fb_mrk_rev_r <= '0;
    end else if (fb_marker) begin
      fb_mrk_pos_r <= fb_pos;
      fb_mrk_rev_r <= fb_rev;
    end
  end

  // ****************************************
  // flags and interrupt status
  // ****************************************
  // set wins over a same-cycle clear
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_EVENTS; gi++) begin : g_flag
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          flag_r[gi] <= 1'b0;
          stat_r[gi] <= 1'b0;
        end else begin
          flag_r[gi] <= ev[gi] | (flag_r[gi] & ~flag_clr[gi]);
          stat_r[gi] <= ev[gi] | (stat_r[gi] & ~stat_clr[gi]);
        end
      end
    end
  endgenerate

  // level interrupt from unmasked status
  assign irq = |(stat_r & mask_r);

endmodule : encoder_freeze_marker_capture

// >>> rtl/freeze_capture_params.svh
// How it works
// - input zero is the freeze trigger
// - reference freeze stores revolutions and position
// - feedback freeze stores revolutions and position
// - edge select zero rising, one falling
// - freeze results written only when enabled
// - freeze event sets both freeze flags
// - enabled: reinitialise command sets trigger sources to four
// - primary source selects first freeze unit
// - secondary source selects second freeze unit
// - reference marker stores position and revolutions
// - feedback marker stores position and revolutions
// - reference marker flag set, user clears
// - feedback marker flag set, user clears
`ifndef FREEZE_CAPTURE_PARAMS_SVH
`define FREEZE_CAPTURE_PARAMS_SVH
// ****************************************
// register offsets
// ****************************************
`define OFS_CTRL 8'h00
`define OFS_STAT 8'h04
`define OFS_MASK 8'h08
`define OFS_FLAGS 8'h0C
`define OFS_REF_FRZ_POS 8'h10
`define OFS_REF_FRZ_REV 8'h14
`define OFS_FB_FRZ_POS 8'h18
`define OFS_FB_FRZ_REV 8'h1C
`define OFS_REF_MRK_POS 8'h20
`define OFS_REF_MRK_REV 8'h24
`define OFS_FB_MRK_POS 8'h28
`define OFS_FB_MRK_REV 8'h2C
`define OFS_TRIG_SRC 8'h30
// ****************************************
// control fields and values
// ****************************************
`define CTRL_EN_BIT 0
`define CTRL_EDGE_BIT 1
`define CTRL_REINITIALISE_COMMAND_BIT 2
`define CTRL_REF_SEL_BIT 3
`define CTRL_FB_SEL_BIT 4
`define TRIG_COMMON_LINE 8'h04
`define TRIG_RESET_VAL 8'h00
`define FREEZE_IN_BIT 0
`define FLAG_REF_FRZ 0
`define FLAG_FB_FRZ 1
`define FLAG_REF_MRK 2
`define FLAG_FB_MRK 3
`define NUM_EVENTS 4
`endif

// >>> rtl/freeze_capture_pkg.sv
package freeze_capture_pkg;
  // which freeze unit a channel uses
  typedef enum logic [0:0] {
    UNIT_FIRST = 1'b0,
    UNIT_SECOND = 1'b1
  } freeze_unit_t;
endpackage : freeze_capture_pkg
